// file: verilog/rmsl_pkg.sv
package rmsl_pkg;
    // register map
    localparam logic [7:0] RMSL_CTRL_OFS = 8'h00;
    localparam logic [7:0] RMSL_STAT_OFS = 8'h04;
    localparam logic [31:0] RMSL_CTRL_RST = 32'h0000_0000;
    // control fields
    localparam int RMSL_CTRL_DMA_GRP = 0;
    localparam int RMSL_CTRL_IRQ_GRP = 1;
    // status fields
    localparam int RMSL_STAT_BUS_MUX = 0;
    localparam int RMSL_STAT_BIG_END = 1;
    localparam int RMSL_STAT_SGL_BOOT = 2;
    localparam int RMSL_STAT_VALID = 3;
    localparam int RMSL_STAT_WIDTH_OK = 4;
    localparam int RMSL_STAT_DMA_GRP = 5;
    localparam int RMSL_STAT_IRQ_GRP = 6;
    // strap vector layout
    localparam int RMSL_STRAP_W = 3;
    localparam int RMSL_STRAP_BUS = 0;
    localparam int RMSL_STRAP_END = 1;
    localparam int RMSL_STRAP_BOOT = 2;
    // latched values while reset is held
    localparam logic RMSL_BUS_MUX_RST = 1'b0;
    localparam logic RMSL_BIG_END_RST = 1'b0;
    localparam logic RMSL_BOOT_PIN_RST = 1'b1;
    // channel, line and stage counts
    localparam int RMSL_DMA_CH = 2;
    localparam int RMSL_IRQ_N = 5;
    localparam int RMSL_TIE_W = 2;
    localparam int RMSL_SYNC_STAGES = 2;
endpackage : rmsl_pkg

// file: verilog/rmsl_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs; free running so it tracks pins during reset
module rmsl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_core_clk,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge i_core_clk) begin
        meta_r <= i_async;
        sync_r <= meta_r;
    end

    assign o_sync = sync_r;
endmodule : rmsl_sync

// file: verilog/rmsl_strap_latch.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R01] bus organisation strap sampled at reset release
// [R02] byte order strap sampled at reset release
// [R03] low boot strap at release: single boot
// [R04] board holds straps stable around release
// [R05] board pulls boot strap high normally
// [R06] board ties both width pins high
// [R07] dma channels 2,3 on one group only
// [R08] irq lines 0..4 on one group only
// [R09] latched modes stay fixed until next reset
module rmsl_strap_latch
    import rmsl_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_bus_org_strap,
    input wire logic i_byte_order_strap,
    input wire logic i_boot_strap,
    input wire logic [RMSL_TIE_W-1:0] i_width_tie_pins,
    input wire logic [RMSL_DMA_CH-1:0] i_port_group_a_req,
    input wire logic [RMSL_DMA_CH-1:0] i_port_group_b_req,
    input wire logic [RMSL_DMA_CH-1:0] i_dma_acknowledge,
    input wire logic [RMSL_IRQ_N-1:0] i_irq_group_a_pins,
    input wire logic [RMSL_IRQ_N-1:0] i_irq_group_b_pins,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_bus_mux,
    output logic o_big_endian,
    output logic o_single_boot,
    output logic o_cfg_valid,
    output logic [RMSL_DMA_CH-1:0] o_dma_request,
    output logic [RMSL_DMA_CH-1:0] o_port_group_a_ack,
    output logic o_port_group_a_ack_oe_n,
    output logic [RMSL_DMA_CH-1:0] o_port_group_b_ack,
    output logic o_port_group_b_ack_oe_n,
    output logic [RMSL_IRQ_N-1:0] o_ext_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [RMSL_STRAP_W-1:0] strap_s;
    logic [RMSL_TIE_W-1:0] tie_s;
    logic [RMSL_DMA_CH-1:0] req_a_s;
    logic [RMSL_DMA_CH-1:0] req_b_s;
    logic [RMSL_IRQ_N-1:0] irq_a_s;
    logic [RMSL_IRQ_N-1:0] irq_b_s;

    rmsl_sync #(.WIDTH(RMSL_STRAP_W)) u_sync_strap (
        .i_core_clk(i_core_clk),
        .i_async({i_boot_strap, i_byte_order_strap, i_bus_org_strap}),
        .o_sync(strap_s)
    );
    rmsl_sync #(.WIDTH(RMSL_TIE_W)) u_sync_tie (
        .i_core_clk(i_core_clk),
        .i_async(i_width_tie_pins),
        .o_sync(tie_s)
    );
    rmsl_sync #(.WIDTH(RMSL_DMA_CH)) u_sync_req_a (
        .i_core_clk(i_core_clk),
        .i_async(i_port_group_a_req),
        .o_sync(req_a_s)
    );
    rmsl_sync #(.WIDTH(RMSL_DMA_CH)) u_sync_req_b (
        .i_core_clk(i_core_clk),
        .i_async(i_port_group_b_req),
        .o_sync(req_b_s)
    );
    rmsl_sync #(.WIDTH(RMSL_IRQ_N)) u_sync_irq_a (
        .i_core_clk(i_core_clk),
        .i_async(i_irq_group_a_pins),
        .o_sync(irq_a_s)
    );
    rmsl_sync #(.WIDTH(RMSL_IRQ_N)) u_sync_irq_b (
        .i_core_clk(i_core_clk),
        .i_async(i_irq_group_b_pins),
        .o_sync(irq_b_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // strap capture at the release of reset

    logic rst_d_r;
    logic release_evt;
    logic bus_mux_r;
    logic big_endian_r;
    logic boot_pin_r;
    logic cfg_valid_r;

    always_ff @(posedge i_core_clk) begin
        rst_d_r <= i_reset;
    end

    assign release_evt = rst_d_r && !i_reset;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            bus_mux_r <= RMSL_BUS_MUX_RST;
            big_endian_r <= RMSL_BIG_END_RST;
            boot_pin_r <= RMSL_BOOT_PIN_RST;
        end else if (release_evt) begin
            bus_mux_r <= strap_s[RMSL_STRAP_BUS]; // see [R01]
            big_endian_r <= strap_s[RMSL_STRAP_END]; // see [R02]
            boot_pin_r <= strap_s[RMSL_STRAP_BOOT]; // see [R03]
        end
        // no other path: values held until reset returns, see [R09]
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cfg_valid_r <= 1'b0;
        end else if (release_evt) begin
            cfg_valid_r <= 1'b1;
        end
    end

    assign o_bus_mux = bus_mux_r;
    assign o_big_endian = big_endian_r;
    assign o_single_boot = !boot_pin_r;
    assign o_cfg_valid = cfg_valid_r;

    ////////////////////////////////////////////////////////////////////////////////
    // register port

    logic dma_grp_r;
    logic irq_grp_r;
    logic [31:0] rdata_r;
    logic [31:0] stat_word;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            dma_grp_r <= RMSL_CTRL_RST[RMSL_CTRL_DMA_GRP];
            irq_grp_r <= RMSL_CTRL_RST[RMSL_CTRL_IRQ_GRP];
        end else if (i_wr && i_addr == RMSL_CTRL_OFS) begin
            dma_grp_r <= i_wdata[RMSL_CTRL_DMA_GRP];
            irq_grp_r <= i_wdata[RMSL_CTRL_IRQ_GRP];
        end
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[RMSL_STAT_BUS_MUX] = bus_mux_r;
        stat_word[RMSL_STAT_BIG_END] = big_endian_r;
        stat_word[RMSL_STAT_SGL_BOOT] = !boot_pin_r;
        stat_word[RMSL_STAT_VALID] = cfg_valid_r;
        stat_word[RMSL_STAT_WIDTH_OK] = &tie_s;
        stat_word[RMSL_STAT_DMA_GRP] = dma_grp_r;
        stat_word[RMSL_STAT_IRQ_GRP] = irq_grp_r;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (i_rd && i_addr == RMSL_CTRL_OFS) begin
            rdata_r <= {30'h0, irq_grp_r, dma_grp_r};
        end else if (i_rd && i_addr == RMSL_STAT_OFS) begin
            rdata_r <= stat_word;
        end else begin
            // unmapped reads and idle cycles return zero
            rdata_r <= 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // port group routing

    logic [RMSL_DMA_CH-1:0] dma_req_r;
    logic [RMSL_DMA_CH-1:0] ack_a_r;
    logic [RMSL_DMA_CH-1:0] ack_b_r;
    logic ack_a_oe_n_r;
    logic ack_b_oe_n_r;
    logic [RMSL_IRQ_N-1:0] ext_irq_r;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            dma_req_r <= '0;
            ack_a_r <= '0;
            ack_b_r <= '0;
            ack_a_oe_n_r <= 1'b1;
            ack_b_oe_n_r <= 1'b1;
        end else begin
            // only the selected group is listened to and driven, see [R07]
            dma_req_r <= dma_grp_r ? req_b_s : req_a_s;
            ack_a_r <= dma_grp_r ? '0 : i_dma_acknowledge;
            ack_b_r <= dma_grp_r ? i_dma_acknowledge : '0;
            ack_a_oe_n_r <= dma_grp_r;
            ack_b_oe_n_r <= !dma_grp_r;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            ext_irq_r <= '0;
        end else begin
            ext_irq_r <= irq_grp_r ? irq_b_s : irq_a_s; // see [R08]
        end
    end

    assign o_dma_request = dma_req_r;
    assign o_port_group_a_ack = ack_a_r;
    assign o_port_group_a_ack_oe_n = ack_a_oe_n_r;
    assign o_port_group_b_ack = ack_b_r;
    assign o_port_group_b_ack_oe_n = ack_b_oe_n_r;
    assign o_ext_irq = ext_irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    bus_latch_a: assert property (@(posedge i_core_clk) // see [R01]
        release_evt |=> o_bus_mux == $past(strap_s[RMSL_STRAP_BUS]))
        else $error("bus organisation not captured at release");

    endian_latch_a: assert property (@(posedge i_core_clk) // see [R02]
        release_evt |=> o_big_endian == $past(strap_s[RMSL_STRAP_END]))
        else $error("byte order not captured at release");

    boot_latch_a: assert property (@(posedge i_core_clk) // see [R03]
        release_evt |=> o_single_boot == !$past(strap_s[RMSL_STRAP_BOOT]))
        else $error("boot mode not captured at release");

    cfg_hold_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // see [R09]
        o_cfg_valid |=> (i_reset || ($stable(o_bus_mux) && $stable(o_big_endian)
            && $stable(o_single_boot))))
        else $error("latched mode changed after release");

    valid_rise_a: assert property (@(posedge i_core_clk) // see [R09]
        release_evt ##1 !i_reset |-> o_cfg_valid)
        else $error("config valid did not rise after release");

    dma_excl_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // see [R07]
        !(!o_port_group_a_ack_oe_n && !o_port_group_b_ack_oe_n))
        else $error("both dma groups driven at once");

    // the reset term repeats the disable iff: the release cycle is checked, outputs load there from live inputs
    dma_route_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // see [R07]
        !i_reset && $stable(dma_grp_r) && !dma_grp_r
            |=> o_port_group_a_ack == $past(i_dma_acknowledge)
            && o_port_group_b_ack == '0 && o_dma_request == $past(req_a_s))
        else $error("dma group a routing wrong");

    irq_route_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // see [R08]
        !i_reset && irq_grp_r ##1 irq_grp_r |-> o_ext_irq == $past(irq_b_s))
        else $error("irq group b routing wrong");

    irq_route_grp_a_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // see [R08]
        !i_reset && !irq_grp_r ##1 !irq_grp_r |-> o_ext_irq == $past(irq_a_s))
        else $error("irq group a routing wrong");

    release_cov_c: cover property (@(posedge i_core_clk) release_evt ##1 o_single_boot);
    mux_bus_cov_c: cover property (@(posedge i_core_clk) release_evt ##1 o_bus_mux);
    dma_swap_cov_c: cover property (@(posedge i_core_clk) disable iff (i_reset)
        !dma_grp_r ##1 dma_grp_r ##2 !o_port_group_b_ack_oe_n);
    irq_b_cov_c: cover property (@(posedge i_core_clk) disable iff (i_reset)
        irq_grp_r && |o_ext_irq);

endmodule : rmsl_strap_latch

// file: sim/rmsl_board.sv
`timescale 1ns/1ps
// board side of the strap pins: resistors set the wanted levels while reset is held
module rmsl_board
    import rmsl_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [RMSL_STRAP_W-1:0] i_want,
    output logic [RMSL_STRAP_W-1:0] o_straps,
    output logic [RMSL_TIE_W-1:0] o_width_tie_pins
);
    logic reset_d_r = 1'b1;

    assign o_width_tie_pins = '1;

    // pins never move in the clock that follows reset release
    always @(posedge i_core_clk) begin
        reset_d_r <= i_reset;
        if (!(reset_d_r && !i_reset)) begin
            o_straps <= i_want;
        end
    end
endmodule : rmsl_board

// file: sim/rmsl_strap_latch_tb.sv
`timescale 1ns/1ps
module rmsl_strap_latch_tb;
    import rmsl_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [2:0] want = 3'h4;
    logic [2:0] straps;
    logic [1:0] ties;
    logic [1:0] req_a = '0;
    logic [1:0] req_b = '0;
    logic [1:0] ack = '0;
    logic [4:0] irq_a = '0;
    logic [4:0] irq_b = '0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic bus_mux, big_end, sgl_boot, cfg_valid, oe_a_n, oe_b_n;
    logic [1:0] dma_req, ack_a, ack_b;
    logic [4:0] ext_irq;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    initial begin
        forever #20 i_core_clk = ~i_core_clk;
    end

    rmsl_board u_rmsl_board (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_want(want),
        .o_straps(straps), .o_width_tie_pins(ties));

    rmsl_strap_latch u_rmsl_strap_latch (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_bus_org_strap(straps[RMSL_STRAP_BUS]), .i_byte_order_strap(straps[RMSL_STRAP_END]),
        .i_boot_strap(straps[RMSL_STRAP_BOOT]), .i_width_tie_pins(ties),
        .i_port_group_a_req(req_a), .i_port_group_b_req(req_b), .i_dma_acknowledge(ack),
        .i_irq_group_a_pins(irq_a), .i_irq_group_b_pins(irq_b), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_bus_mux(bus_mux),
        .o_big_endian(big_end), .o_single_boot(sgl_boot), .o_cfg_valid(cfg_valid),
        .o_dma_request(dma_req), .o_port_group_a_ack(ack_a),
        .o_port_group_a_ack_oe_n(oe_a_n), .o_port_group_b_ack(ack_b),
        .o_port_group_b_ack_oe_n(oe_b_n), .o_ext_irq(ext_irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_core_clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_core_clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge i_core_clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, e);
        // read data stand for one cycle only
        @(posedge i_core_clk);
        #1;
        chk(rdata, 32'h0);
    endtask : rd

    // reset with wanted strap levels, then release and let the latch settle
    task automatic do_reset(input logic [2:0] w, input int n);
        @(posedge i_core_clk);
        i_reset <= 1'b1;
        want <= w;
        repeat (n) @(posedge i_core_clk);
        #1;
        chk({cfg_valid, bus_mux, big_end, sgl_boot, oe_a_n, oe_b_n}, 32'h3);
        @(posedge i_core_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask : do_reset

    // route outputs packed as irq, dma req, ack a, oe a, ack b, oe b
    function automatic logic [31:0] routes();
        return {ext_irq, dma_req, ack_a, oe_a_n, ack_b, oe_b_n};
    endfunction : routes

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        for (int k = 0; k < 8; k++) begin
            do_reset(k[2:0], (k == 0) ? 10 : 5);
            chk({cfg_valid, sgl_boot, big_end, bus_mux}, {1'b1, ~k[2], k[1], k[0]});
            rd(RMSL_STAT_OFS, {25'h0, 4'h3, ~k[2], k[1], k[0]});
            @(posedge i_core_clk);
            want <= ~k[2:0];
            repeat (6) @(posedge i_core_clk);
            #1;
            chk({cfg_valid, sgl_boot, big_end, bus_mux}, {1'b1, ~k[2], k[1], k[0]});
        end
        $display("test straps done");
        @(posedge i_core_clk);
        irq_a <= 5'h15;
        irq_b <= 5'h0a;
        req_a <= 2'h1;
        req_b <= 2'h2;
        ack <= 2'h3;
        repeat (4) @(posedge i_core_clk);
        #1;
        chk(routes(), {5'h15, 2'h1, 2'h3, 1'b0, 2'h0, 1'b1});
        wr(RMSL_CTRL_OFS, 32'h3);
        repeat (3) @(posedge i_core_clk);
        #1;
        chk(routes(), {5'h0a, 2'h2, 2'h0, 1'b1, 2'h3, 1'b0});
        rd(RMSL_CTRL_OFS, 32'h3);
        wr(RMSL_STAT_OFS, 32'h0);
        rd(RMSL_STAT_OFS, 32'h7b);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, 32'h0);
        wr(RMSL_CTRL_OFS, 32'h1);
        repeat (3) @(posedge i_core_clk);
        #1;
        chk(routes(), {5'h15, 2'h2, 2'h0, 1'b1, 2'h3, 1'b0});
        // mid-run reset with routed pins active: group a again, straps recaptured
        do_reset(3'h4, 5);
        chk({cfg_valid, sgl_boot, big_end, bus_mux}, 4'h8);
        chk(routes(), {5'h15, 2'h1, 2'h3, 1'b0, 2'h0, 1'b1});
        rd(RMSL_CTRL_OFS, 32'h0);
        $display("test routing done");
        finish_test();
    end
endmodule : rmsl_strap_latch_tb
